// file: hw/abu_consts.vh
`ifndef ABU_CONSTS_VH
`define ABU_CONSTS_VH
// register indexes inside the bus window; the byte address is four times the index
`define ABU_OFF_ADDR_HIGH 16'hfe0c
`define ABU_OFF_ADDR_LOW 16'hfe0d
`define ABU_OFF_STATUS_CTRL 16'hfe0e
`define ABU_OFF_FLAG_CTRL 16'hfe0f
`define ABU_OFF_IRQ_STATUS 16'hfe10
`define ABU_OFF_IRQ_MASK 16'hfe11
`define ABU_OFF_SYS_STATUS 16'hfe12
// word index of the printed offsets: byte address is four times the index
`define ABU_WORD_SHIFT 2
// field positions in the status/control register
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
// field position of the flag clear enable
`define ABU_BIT_FLAG_CLR 7
// field position of the wait exit indicator
`define ABU_BIT_WAIT_EXIT 1
// interrupt status bits
`define ABU_IRQ_MATCH 0
`define ABU_IRQ_SOFT 1
`define ABU_IRQ_WIDTH 2
// reset values
`define ABU_RST_BYTE 8'h00
`define ABU_RST_WORD 32'h0000_0000
`define ABU_RST_IRQ 2'h0
// forced trap vectors, user and monitor page
`define ABU_VEC_USER 16'hfffc
`define ABU_VEC_MON 16'hfefc
// ahb transfer type and response codes
`define ABU_HTRANS_NONSEQ 2'h2
`define ABU_HTRANS_SEQ 2'h3
`define ABU_HRESP_OKAY 1'h0
`endif

// file: hw/abu_match.v
`timescale 1ns/1ps
// registered compare of the cpu address against the breakpoint address
module abu_match #(
    parameter AW = 16 // address width
) (
    input wire hclk, // bus clock
    input wire hresetn, // async reset, active low
    input wire clk_en, // freezes state while low
    input wire [AW-1:0] cpu_addr, // cpu generated address
    input wire addr_valid, // address comes from the program counter
    input wire [AW-1:0] bp_addr, // breakpoint address
    input wire armed, // matching allowed
    output reg hit_q // registered hit, high one cycle after each matching address
);
    // compare is combinational, registered once to ease timing
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hit_q <= 1'b0;
        else if (clk_en)
            hit_q <= armed && addr_valid && (cpu_addr == bp_addr); // RL1
    end
endmodule

// file: hw/abu_irq.v
`timescale 1ns/1ps
`include "abu_consts.vh"
// sticky event bits, read clears, masked onto one level output
module abu_irq #(
    parameter W = 2 // number of event bits
) (
    input wire hclk, // bus clock
    input wire hresetn, // async reset, active low
    input wire clk_en, // freezes state while low
    input wire [W-1:0] evt, // event pulses
    input wire rd_clr, // status read taken
    input wire [W-1:0] mask_in, // mask register
    output reg [W-1:0] stat_q, // sticky status
    output reg irq_q // interrupt level
);
    genvar i;
    // set beats the read clear in the same cycle
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    stat_q[i] <= 1'b0;
                else if (clk_en)
                begin
                    if (evt[i])
                        stat_q[i] <= 1'b1;
                    else if (rd_clr)
                        stat_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
    // level output, one cycle behind the status
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_q <= 1'b0;
        else if (clk_en)
            irq_q <= |(stat_q & mask_in);
    end
endmodule

// file: hw/abu_top.v
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "abu_consts.vh"
// Functional notes
// RL1: enabled address equal to breakpoint raises request
// RL2: cpu finishes instruction, takes forced trap vector
// RL3: match on last cycle breaks at once
// RL4: writing one to active bit forces break
// RL5: return from interrupt ends break state
// RL6: timer counter halted during break
// RL7: watchdog off in break under test voltage
// RL8: flags clearable in break only when enabled
// RL9: active in wait; wait exit indicator recorded
// RL10: inactive in stop, registers kept
// RL11: enable bit seven, read write, reset clear
// RL12: active bit sets on match, software clears
// RL13: address bytes hold breakpoint, reset to zero
// RL14: active at bit six, others read zero
module abu_top #(
    parameter AW = 16 // cpu address width
) (
    input wire hclk, // bus clock
    input wire hresetn, // async reset, active low
    input wire clk_en, // freezes all state while low
    input wire hsel, // slave select
    input wire [31:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write transfer
    input wire [2:0] hsize, // transfer size
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready
    output reg [31:0] hrdata, // read data
    output reg hreadyout, // slave ready
    output reg hresp, // response, always okay
    input wire [AW-1:0] cpu_addr, // cpu address bus
    input wire cpu_addr_pc, // address comes from program counter
    input wire cpu_last_cycle, // last cycle of current instruction
    input wire cpu_rti_done, // return from interrupt retired
    input wire cpu_trap_taken, // forced trap has been loaded
    input wire monitor_mode, // monitor vector page in use
    input wire wait_mode, // cpu in wait
    input wire stop_mode, // cpu in stop
    input wire test_voltage, // high voltage present on reset pin
    output reg brk_req_q, // break request to sequencer
    output reg brk_at_once_q, // break starts without instruction end
    output reg [AW-1:0] brk_vector_q, // vector to fetch for trap
    output reg brk_state_q, // break interrupt in progress
    output reg timer_halt_q, // stop the timer counter
    output reg watchdog_off_q, // hold the watchdog disabled
    output reg flag_clr_ok_q, // software may clear status flags
    output reg irq_q // interrupt level
);
    // register file
    reg [7:0] addr_high_q; // breakpoint address high byte
    reg [7:0] addr_low_q; // breakpoint address low byte
    reg enable_q; // match break enable
    reg active_q; // break active flag
    reg flag_clr_en_q; // flag clear enable
    reg wait_exit_q; // wait left by break
    reg [`ABU_IRQ_WIDTH-1:0] mask_q; // interrupt mask
    // address phase capture
    reg dp_valid_q; // data phase pending
    reg dp_write_q; // pending is a write
    reg [15:0] dp_addr_q; // pending byte address
    reg last_q; // match cycle was the last of its instruction
    wire hit; // address hit pulse
    wire [`ABU_IRQ_WIDTH-1:0] stat; // sticky status
    wire irq_w; // interrupt from helper
    wire ap_take; // address phase accepted
    wire wr_now; // write data phase now
    wire [7:0] wb; // written byte
    wire soft_brk; // software forced break
    wire sel_stat_rd; // status read
    reg [31:0] rd_mux; // read data select
    // decoded strobes, shared by every process that needs them
    wire wr_addr_high; // write to breakpoint high byte
    wire wr_addr_low; // write to breakpoint low byte
    wire wr_status_ctrl; // write to status/control
    wire wr_flag_ctrl; // write to flag control
    wire wr_irq_mask; // write to interrupt mask
    wire wr_sys_status; // write to system break status
    wire rd_pending; // read data phase in progress

    // address decode: printed offsets are indexes, byte address is four times
    function [15:0] idx_addr;
        input [15:0] idx;
        begin
            idx_addr = idx << `ABU_WORD_SHIFT;
        end
    endfunction

    // only the low half of haddr is decoded, so the window repeats
    // every 64k bytes; the system decoder must keep hsel narrow
    function dp_is;
        input [15:0] addr; // captured byte address
        input [15:0] idx; // register index
        begin
            dp_is = (addr == idx_addr(idx));
        end
    endfunction

    // address phase is taken only once the previous one has completed
    assign ap_take = hsel && hready && htrans[1];
    assign wr_now = dp_valid_q && dp_write_q;
    assign wb = hwdata[7:0];
    // narrow writes are not refused: every register sits in the low byte
    assign rd_pending = dp_valid_q && !dp_write_q;
    // per register write strobes
    assign wr_addr_high = wr_now && dp_is(dp_addr_q, `ABU_OFF_ADDR_HIGH);
    assign wr_addr_low = wr_now && dp_is(dp_addr_q, `ABU_OFF_ADDR_LOW);
    assign wr_status_ctrl = wr_now && dp_is(dp_addr_q, `ABU_OFF_STATUS_CTRL);
    assign wr_flag_ctrl = wr_now && dp_is(dp_addr_q, `ABU_OFF_FLAG_CTRL);
    assign wr_irq_mask = wr_now && dp_is(dp_addr_q, `ABU_OFF_IRQ_MASK);
    assign wr_sys_status = wr_now && dp_is(dp_addr_q, `ABU_OFF_SYS_STATUS);
    // a write of one to the active bit forces a break
    assign soft_brk = wr_status_ctrl && wb[`ABU_BIT_ACTIVE]; // RL4
    // reading the status register clears it at the end of the wait state, on the edge that loads hrdata
    assign sel_stat_rd = rd_pending && dp_is(dp_addr_q, `ABU_OFF_IRQ_STATUS);

    // compare runs only while enabled and not in stop
    // the hit pulse is one cycle behind the address it saw
    abu_match #(
        .AW(AW)
    ) u_match (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .cpu_addr(cpu_addr),
        .addr_valid(cpu_addr_pc),
        .bp_addr({addr_high_q, addr_low_q}),
        .armed(enable_q && !stop_mode), // RL10
        .hit_q(hit)
    );

    // match and forced break events
    // status bit 0 is the address hit, bit 1 the forced break
    abu_irq #(
        .W(`ABU_IRQ_WIDTH)
    ) u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .evt({soft_brk, hit}),
        .rd_clr(sel_stat_rd),
        .mask_in(mask_q),
        .stat_q(stat),
        .irq_q(irq_w)
    );

    // bus data phase tracking; writes take no wait state, reads one
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 16'h0000;
            last_q <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= `ABU_HRESP_OKAY;
        end
        else if (clk_en)
        begin
            dp_valid_q <= ap_take;
            // only whole word transfers are expected
            if (ap_take)
            begin
                dp_write_q <= hwrite;
                dp_addr_q <= haddr[15:0];
            end
            // a read costs one wait state so that hrdata is registered
            // from the captured address and still stands at the end of
            // its data phase; writes complete with no wait
            hreadyout <= !(ap_take && !hwrite);
            hresp <= `ABU_HRESP_OKAY;
            // last cycle flag lines up with the registered hit pulse
            last_q <= cpu_last_cycle; // RL3
        end
    end

    // register writes; stop mode leaves contents alone
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_high_q <= `ABU_RST_BYTE; // RL13
            addr_low_q <= `ABU_RST_BYTE; // RL13
            enable_q <= 1'b0; // RL11
            active_q <= 1'b0; // RL12
            flag_clr_en_q <= 1'b0;
            mask_q <= `ABU_RST_IRQ;
        end
        else if (clk_en)
        begin
            if (wr_addr_high)
                addr_high_q <= wb; // RL13
            if (wr_addr_low)
                addr_low_q <= wb; // RL13
            if (wr_status_ctrl)
                enable_q <= wb[`ABU_BIT_ENABLE]; // RL11
            // the enable only gates the permission output below
            if (wr_flag_ctrl)
                flag_clr_en_q <= wb[`ABU_BIT_FLAG_CLR]; // RL8
            if (wr_irq_mask)
                mask_q <= wb[`ABU_IRQ_WIDTH-1:0];
            // hardware set beats a software clear in the same cycle
            if (hit || soft_brk)
                active_q <= 1'b1; // RL12
            else if (wr_status_ctrl)
                active_q <= 1'b0; // RL12
        end
    end

    // break sequencing towards the cpu
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            brk_req_q <= 1'b0;
            brk_at_once_q <= 1'b0;
            brk_vector_q <= `ABU_VEC_USER;
            brk_state_q <= 1'b0;
            wait_exit_q <= 1'b0;
        end
        else if (clk_en)
        begin
            // request held until the sequencer loads the trap
            // a second event while pending refreshes the vector and the at-once flag
            if (hit || soft_brk)
            begin
                brk_req_q <= 1'b1; // RL1
                brk_at_once_q <= hit && last_q; // RL3
                brk_vector_q <= monitor_mode ? `ABU_VEC_MON : `ABU_VEC_USER; // RL2
            end
            else if (cpu_trap_taken)
            begin
                brk_req_q <= 1'b0; // RL2
                brk_at_once_q <= 1'b0;
            end
            // break state spans trap entry to its return
            if (cpu_trap_taken && brk_req_q)
                brk_state_q <= 1'b1;
            else if (cpu_rti_done)
                brk_state_q <= 1'b0; // RL5
            // wait exit indicator: break taken while in wait
            if ((hit || soft_brk) && wait_mode)
                wait_exit_q <= 1'b1; // RL9
            else if (wr_sys_status)
                wait_exit_q <= wb[`ABU_BIT_WAIT_EXIT];
        end
    end

    // side effects of the break state on other modules
    // they trail the break state by a cycle so each output is a flop
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer_halt_q <= 1'b0;
            watchdog_off_q <= 1'b0;
            flag_clr_ok_q <= 1'b1;
            irq_q <= 1'b0;
        end
        else if (clk_en)
        begin
            timer_halt_q <= brk_state_q; // RL6
            watchdog_off_q <= brk_state_q && test_voltage; // RL7
            flag_clr_ok_q <= !brk_state_q || flag_clr_en_q; // RL8
            irq_q <= irq_w;
        end
    end

    // read data select; unmapped reads return zero
    always @*
    begin
        rd_mux = `ABU_RST_WORD;
        case (dp_addr_q)
            idx_addr(`ABU_OFF_ADDR_HIGH): rd_mux[7:0] = addr_high_q;
            idx_addr(`ABU_OFF_ADDR_LOW): rd_mux[7:0] = addr_low_q;
            idx_addr(`ABU_OFF_STATUS_CTRL):
            begin
                rd_mux[`ABU_BIT_ENABLE] = enable_q; // RL14
                rd_mux[`ABU_BIT_ACTIVE] = active_q; // RL14
            end
            idx_addr(`ABU_OFF_FLAG_CTRL): rd_mux[`ABU_BIT_FLAG_CLR] = flag_clr_en_q;
            idx_addr(`ABU_OFF_IRQ_STATUS): rd_mux[`ABU_IRQ_WIDTH-1:0] = stat;
            idx_addr(`ABU_OFF_IRQ_MASK): rd_mux[`ABU_IRQ_WIDTH-1:0] = mask_q;
            idx_addr(`ABU_OFF_SYS_STATUS): rd_mux[`ABU_BIT_WAIT_EXIT] = wait_exit_q; // RL9
            default: rd_mux = `ABU_RST_WORD;
        endcase
    end

    // registered read data: loaded at the end of the wait state from the
    // captured address, so a write that landed just before is seen;
    // between reads it keeps its value, so a status clear that follows
    // the read cannot change what the master takes
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= `ABU_RST_WORD;
        else if (clk_en && rd_pending)
            hrdata <= rd_mux;
    end
endmodule

// file: verification/abu_checker.sv
`timescale 1ns/1ps
`include "abu_consts.vh"
// port checks; bus writes are shadowed so the breakpoint setup is known
module abu_checker #(
    parameter AW = 16 // address width
) (
    input wire hclk, // clock
    input wire hresetn, // reset
    input wire clk_en, // run
    input wire hsel, // select
    input wire [31:0] haddr, // address
    input wire [1:0] htrans, // type
    input wire hwrite, // write
    input wire [31:0] hwdata, // write data
    input wire hready, // ready in
    input wire hreadyout, // ready out
    input wire hresp, // response
    input wire [AW-1:0] cpu_addr, // cpu address
    input wire cpu_addr_pc, // pc address
    input wire cpu_last_cycle, // last cycle
    input wire cpu_rti_done, // return retired
    input wire cpu_trap_taken, // trap loaded
    input wire monitor_mode, // monitor page
    input wire stop_mode, // stop
    input wire test_voltage, // high voltage
    input wire brk_req_q, // request
    input wire brk_at_once_q, // at once
    input wire [AW-1:0] brk_vector_q, // vector
    input wire brk_state_q, // break state
    input wire timer_halt_q, // timer halt
    input wire watchdog_off_q, // watchdog off
    input wire flag_clr_ok_q // flag clear allowed
);
    reg wr_q; // write data phase pending
    reg [15:0] wa_q; // register index of that write
    reg [7:0] hi_q; // shadow high byte
    reg [7:0] lo_q; // shadow low byte
    reg en_q; // shadow enable
    reg fce_q; // shadow flag clear enable
    // a hit only counts when the bus shadow says it is armed
    wire hit = clk_en && cpu_addr_pc && !stop_mode && en_q && cpu_addr == {hi_q, lo_q};
    // follow each write at its data phase, as the slave does
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            wa_q <= 16'h0;
            {hi_q, lo_q, en_q, fce_q} <= 18'h0;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr[17:2];
            if (wr_q && wa_q == `ABU_OFF_ADDR_HIGH)
                hi_q <= hwdata[7:0];
            if (wr_q && wa_q == `ABU_OFF_ADDR_LOW)
                lo_q <= hwdata[7:0];
            if (wr_q && wa_q == `ABU_OFF_STATUS_CTRL)
                en_q <= hwdata[7];
            if (wr_q && wa_q == `ABU_OFF_FLAG_CTRL)
                fce_q <= hwdata[7];
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (!hresp && (hreadyout || !$past(clk_en)
        || $past(hsel && hready && htrans[1] && !hwrite)))
        else $error("slave stalled or not okay");
    read_wait_a: assert property ((clk_en && hsel && hready && htrans[1] && !hwrite) ##1 clk_en
        |-> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    match_req_a: assert property (hit ##1 clk_en [*2] |-> brk_req_q)
        else $error("match gave no break request");
    last_cycle_a: assert property (hit && cpu_last_cycle ##1 clk_en [*2] |-> brk_at_once_q)
        else $error("last cycle match not flagged");
    trap_state_a: assert property (clk_en && brk_req_q && cpu_trap_taken |=> brk_state_q && !brk_req_q)
        else $error("trap did not enter break state");
    ret_end_a: assert property (clk_en && cpu_rti_done && !cpu_trap_taken |=> !brk_state_q)
        else $error("return did not end break state");
    vector_a: assert property (brk_req_q |-> brk_vector_q == (monitor_mode ? `ABU_VEC_MON : `ABU_VEC_USER))
        else $error("wrong trap vector");
    timer_halt_a: assert property (clk_en |=> timer_halt_q == $past(brk_state_q))
        else $error("timer halt wrong");
    watchdog_off_a: assert property (clk_en |=> watchdog_off_q == ($past(brk_state_q) && $past(test_voltage)))
        else $error("watchdog hold wrong");
    flag_clear_a: assert property (clk_en |=> flag_clr_ok_q == (!$past(brk_state_q) || $past(fce_q)))
        else $error("flag clear permission wrong");
endmodule
bind abu_top abu_checker #(.AW(AW)) i_abu_checker (.*);

// file: verification/abu_cpu_model.sv
`timescale 1ns/1ps
// cpu sequencer stand-in: takes the forced trap, retires the return
module abu_cpu_model (
    input wire hclk, // clock
    input wire hresetn, // reset
    input wire brk_req_q, // break request
    input wire [15:0] brk_vector_q, // trap vector
    output reg [15:0] cpu_addr, // address bus
    output reg cpu_addr_pc, // pc address
    output reg cpu_last_cycle, // last cycle
    output reg cpu_trap_taken, // trap loaded
    output reg cpu_rti_done // return retired
);
    reg [3:0] lat; // cycles of instruction left, set by the bench
    reg [3:0] cnt_q; // wait counter
    reg [15:0] vec_q; // vector fetched at the trap
    initial
    begin
        lat = 4'h0;
        cpu_addr = 16'h0;
        cpu_addr_pc = 1'b0;
        cpu_last_cycle = 1'b0;
        cpu_rti_done = 1'b0;
    end
    // finish the instruction in hand, then load the trap
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cpu_trap_taken <= 1'b0;
            cnt_q <= 4'h0;
        end
        else if (cpu_trap_taken || !brk_req_q)
        begin
            cpu_trap_taken <= 1'b0;
            cnt_q <= 4'h0;
        end
        else if (cnt_q == lat)
        begin
            cpu_trap_taken <= 1'b1;
            vec_q <= brk_vector_q;
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end
    // one pc fetch; afterwards the bus shows the inverse, not the old value
    task fetch(input [15:0] a, input last);
    begin
        @(posedge hclk);
        cpu_addr <= a;
        cpu_addr_pc <= 1'b1;
        cpu_last_cycle <= last;
        @(posedge hclk);
        cpu_addr <= ~a;
        cpu_addr_pc <= 1'b0;
        cpu_last_cycle <= 1'b0;
    end
    endtask
    task ret_intr;
    begin
        @(posedge hclk);
        cpu_rti_done <= 1'b1;
        @(posedge hclk);
        cpu_rti_done <= 1'b0;
    end
    endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
`include "abu_consts.vh"
// scenario bench for the breakpoint unit
module tb;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg clk_en = 1'b1;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0;
    reg monitor_mode = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0, test_voltage = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, cpu_addr_pc, cpu_last_cycle, cpu_rti_done, cpu_trap_taken;
    wire [15:0] cpu_addr, brk_vector_q;
    wire brk_req_q, brk_at_once_q, brk_state_q, timer_halt_q, watchdog_off_q;
    wire flag_clr_ok_q, irq_q;
    integer bad_count = 0, tests_run = 0, cyc = 0;
    abu_top i_abu_top (.hready(hreadyout), .*);
    abu_cpu_model i_abu_cpu_model (.*);
    initial
        forever #2 hclk = ~hclk;
    // a hang is cut short here
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            wrap_up;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // single transfer; read data is taken at the edge that ends the data phase
    task xfer(input w, input [15:0] o, input [31:0] d, output [31:0] q);
    begin
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `ABU_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {14'h0, o, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    end
    endtask
    task wr(input [15:0] o, input [31:0] d);
        reg [31:0] q;
        xfer(1'b1, o, d, q);
    endtask
    task rd_chk(input [15:0] o, input [31:0] e);
        reg [31:0] q;
    begin
        xfer(1'b0, o, 32'h0, q);
        chk(q, e);
    end
    endtask
    // bounded wait for request (k=0) or break state (k=1)
    task wait_sig(input integer k, input exp);
        integer n;
    begin
        n = 0;
        while ((k ? brk_state_q : brk_req_q) !== 1'b1 && n < 12)
        begin
            @(posedge hclk);
            n = n + 1;
        end
        chk(k ? brk_state_q : brk_req_q, exp);
    end
    endtask
    task leave(input [31:0] sc);
    begin
        wr(`ABU_OFF_STATUS_CTRL, sc);
        i_abu_cpu_model.ret_intr;
        @(posedge hclk);
        chk(brk_state_q, 1'b0);
    end
    endtask
    task s_regs;
    begin
        rd_chk(`ABU_OFF_ADDR_HIGH, 32'h0);
        rd_chk(`ABU_OFF_ADDR_LOW, 32'h0);
        rd_chk(`ABU_OFF_STATUS_CTRL, 32'h0);
        wr(`ABU_OFF_ADDR_HIGH, 32'hffff_ff12);
        wr(`ABU_OFF_ADDR_LOW, 32'h34);
        wr(16'hfe20, 32'hff);
        rd_chk(16'hfe20, 32'h0);
        rd_chk(`ABU_OFF_ADDR_HIGH, 32'h12);
        rd_chk(`ABU_OFF_ADDR_LOW, 32'h34);
        wr(`ABU_OFF_STATUS_CTRL, 32'hbf);
        rd_chk(`ABU_OFF_STATUS_CTRL, 32'h80);
    end
    endtask
    // address match break, then the interrupt is read away
    task s_hit(input last);
    begin
        wr(`ABU_OFF_IRQ_MASK, 32'h3);
        i_abu_cpu_model.fetch(16'h1234, last);
        wait_sig(0, 1'b1);
        chk(brk_at_once_q, last);
        rd_chk(`ABU_OFF_STATUS_CTRL, 32'hc0);
        chk(irq_q, 1'b1);
        rd_chk(`ABU_OFF_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq_q, 1'b0);
        wait_sig(1, 1'b1);
        chk(i_abu_cpu_model.vec_q, `ABU_VEC_USER);
        leave(32'h80);
    end
    endtask
    // software break in monitor page under test voltage, event masked
    task s_soft;
    begin
        monitor_mode <= 1'b1;
        test_voltage <= 1'b1;
        wr(`ABU_OFF_IRQ_MASK, 32'h1);
        wr(`ABU_OFF_STATUS_CTRL, 32'h40);
        wait_sig(0, 1'b1);
        wait_sig(1, 1'b1);
        chk(i_abu_cpu_model.vec_q, `ABU_VEC_MON);
        rd_chk(`ABU_OFF_IRQ_STATUS, 32'h2);
        chk(irq_q, 1'b0);
        chk(watchdog_off_q, 1'b1);
        chk(timer_halt_q, 1'b1);
        chk(flag_clr_ok_q, 1'b0);
        wr(`ABU_OFF_FLAG_CTRL, 32'h80);
        repeat (2) @(posedge hclk);
        chk(flag_clr_ok_q, 1'b1);
        leave(32'h0);
        monitor_mode <= 1'b0;
        test_voltage <= 1'b0;
    end
    endtask
    task s_modes;
    begin
        i_abu_cpu_model.fetch(16'h1234, 1'b0);
        wait_sig(0, 1'b0);
        wr(`ABU_OFF_STATUS_CTRL, 32'h80);
        clk_en <= 1'b0;
        i_abu_cpu_model.fetch(16'h1234, 1'b0);
        wait_sig(0, 1'b0);
        clk_en <= 1'b1;
        stop_mode <= 1'b1;
        i_abu_cpu_model.fetch(16'h1234, 1'b0);
        wait_sig(0, 1'b0);
        rd_chk(`ABU_OFF_ADDR_LOW, 32'h34);
        stop_mode <= 1'b0;
        wait_mode <= 1'b1;
        i_abu_cpu_model.fetch(16'h1234, 1'b1);
        wait_sig(1, 1'b1);
        rd_chk(`ABU_OFF_SYS_STATUS, 32'h2);
        wait_mode <= 1'b0;
        wr(`ABU_OFF_SYS_STATUS, 32'h0);
        leave(32'h80);
    end
    endtask
    task wrap_up;
    begin
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        i_abu_cpu_model.lat = 4'h5;
        s_regs;
        s_hit(1'b0);
        i_abu_cpu_model.lat = 4'h0;
        s_hit(1'b1);
        s_soft;
        s_modes;
        wrap_up;
    end
endmodule
